/* File: ipc_pkg.sv */
// shared constants and types for the incremental plotter control block
package ipc_pkg;

  // ********
  // instruction decode
  // ********
  localparam logic [2:0] OPC_IOT = 3'h6; // opcode of an i/o instruction
  localparam int OPC_MSB = 11; // instruction bit 0 is the word's msb
  localparam int OPC_LSB = 9;
  localparam int DEV_MSB = 8; // device code, instruction bits 3..8
  localparam int DEV_LSB = 3;
  localparam int DEV_BIT_SEVEN = 4; // devcode_bit_seven in word order
  localparam int DEV_BIT_EIGHT = 3; // devcode_bit_eight in word order
  localparam logic [5:0] DEV_CODE_A = 6'h28; // octal 50
  localparam logic [5:0] DEV_CODE_B = 6'h29; // octal 51
  localparam logic [5:0] DEV_CODE_C = 6'h2A; // octal 52
  localparam int IOP_ONE = 0; // io_timing_pulse lane of instruction bit 11
  localparam int IOP_TWO = 1; // lane of instruction bit 10
  localparam int IOP_FOUR = 2; // lane of instruction bit 9

  // ********
  // timing
  // ********
  localparam real CLK_KHZ = 125000.0; // clk_sys rate
  localparam real FAST_FIRST_MS = 2.5; // first fast delay
  localparam real FAST_TOTAL_MS = 5.0; // fast motion to done flag
  localparam real SLOW_DELAY_MS = 35.0; // each of the two slow delays
  localparam int FAST_FIRST_CYC = int'(FAST_FIRST_MS * CLK_KHZ);
  localparam int FAST_SECOND_CYC = int'((FAST_TOTAL_MS - FAST_FIRST_MS) * CLK_KHZ);
  localparam int SLOW_DELAY_CYC = int'(SLOW_DELAY_MS * CLK_KHZ);
  localparam int TIMER_W = 23; // holds the longest delay count

  // ********
  // register map (byte addresses) and fields
  // ********
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  localparam int CTRL_SOFT_PRESET = 0; // write one: acts as io preset
  localparam int CTRL_CMD_ENABLE = 1; // zero: i/o commands ignored
  localparam logic CTRL_CMD_ENABLE_RST = 1'b1;
  localparam int ST_DONE = 0; // status: done flag
  localparam int ST_MOTION_LSB = 1; // status: six motion levels
  localparam int ST_PHASE_LSB = 7; // status: five timing phase bits
  localparam int ST_SLOW = 12; // status: slow-motion flip-flop
  localparam int EV_DONE = 0; // event: done flag set
  localparam int EV_FAST = 1; // event: fast motion done
  localparam int EV_SLOW = 2; // event: slow motion done
  localparam int EV_W = 3;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  // ********
  // types
  // ********
  typedef struct packed {
    logic penUp;
    logic penDown;
    logic penLeft;
    logic penRight;
    logic drumUp;
    logic drumDown;
  } ipc_motion_t;

  typedef struct packed {
    logic skipIfDone;
    logic clearDone;
    logic raisePen;
    logic lowerPen;
    logic penStepLeft;
    logic penStepRight;
    logic drumStepUp;
    logic drumStepDown;
  } ipc_cmd_t;

  typedef enum logic [4:0] {
    PH_IDLE = 5'h01,
    PH_FAST1 = 5'h02,
    PH_FAST2 = 5'h04,
    PH_SLOW1 = 5'h08,
    PH_SLOW2 = 5'h10
  } ipc_phase_t;

endpackage

/* File: ipc_delay_timer.sv */
// one-shot down counter used for the chained motion delays
`timescale 1ns/10ps
`default_nettype none
module ipc_delay_timer (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start,
  input wire logic abort,
  input wire logic [ipc_pkg::TIMER_W-1:0] loadCount,
  output logic expire,
  output logic busy
);

  logic [ipc_pkg::TIMER_W-1:0] count; // cycles left

  // ********
  // counting
  // ********
  // expire pulses loadCount cycles after start; restart reloads
  always_ff @(posedge clk_sys) begin
    if (rst || abort) begin
      count <= '0;
      busy <= 1'b0;
      expire <= 1'b0;
    end else if (start) begin
      count <= loadCount - 1'b1;
      busy <= 1'b1;
      expire <= 1'b0;
    end else if (busy && count == '0) begin
      busy <= 1'b0; // done: one pulse only
      expire <= 1'b1;
    end else begin
      count <= busy ? count - 1'b1 : count;
      expire <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* File: ipc_plotter_control.sv */
// plotter control: i/o decode, motion levels, delay chain, done flag, apb
//
// What this block does
// - opcode six marks i/o; next six bits device
// - answer device codes fifty, fifty-one, fifty-two
// - plotter select high only for our codes
// - first-code select when bits seven, eight clear
// - select levels gated with pulses form controls
// - one motion output per set motion flip-flop
// - preset clears done and fast motion flops
// - pen moves and drum steps fast, pen lift slow
// - fast motion: 2.5 ms, second delay, done at 5.0
// - slow: 35 ms, slow done, second 35 ms
// - slow done clears the pen up flop
// - done flag sets after every motion completes
// - done drives low interrupt line, arms skip
// - code fifty pulse one skips when done
// - code fifty pulse two clears done flag
// - pulse four lifts pen (50), lowers (52)
// - pen right with drum step gives diagonal
`timescale 1ns/10ps
`default_nettype none
module ipc_plotter_control #(
  parameter int FAST_FIRST_CYCLES = ipc_pkg::FAST_FIRST_CYC,
  parameter int FAST_SECOND_CYCLES = ipc_pkg::FAST_SECOND_CYC,
  parameter int SLOW_DELAY_CYCLES = ipc_pkg::SLOW_DELAY_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  // host i/o side
  input wire logic [11:0] instrWord,
  input wire logic [2:0] ioTimingPulse,
  input wire logic ioPresetPulse,
  output logic plotterSelectLevel,
  output logic firstCodeSelect,
  output logic firstCodeSelectN,
  output logic skipRequest,
  output logic interruptRequestLineN,
  output logic motionDoneFlag,
  // plotter side
  output ipc_pkg::ipc_motion_t motion,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);

  // ********
  // declarations
  // ********
  logic isIot; // opcode field says i/o
  logic [5:0] devCode; // device code field
  logic selPlotter; // combinational select for gating
  logic selFirst; // code 50
  logic selBit7; // code 52
  logic selBit8; // code 51
  ipc_pkg::ipc_cmd_t cmd; // gated control pulses
  logic presetNow; // io preset or soft preset
  logic softPreset; // one-cycle pulse from ctrl write
  logic cmdEnable; // ctrl: accept i/o commands
  logic slowFlop; // slow motion in progress
  ipc_pkg::ipc_phase_t phase; // delay chain state
  ipc_pkg::ipc_phase_t next_phase;
  logic timerStart; // load the delay timer
  logic [ipc_pkg::TIMER_W-1:0] timerLoad; // its count
  logic timerExpire; // delay over
  logic fastMotionDone; // clears fast flops
  logic slowMotionDone; // clears pen up
  logic setDone; // done flag set event
  logic anyFast; // any fast motion flop set
  logic [ipc_pkg::EV_W-1:0] irqStat; // sticky events
  logic [ipc_pkg::EV_W-1:0] irqMask; // enables
  logic [ipc_pkg::EV_W-1:0] events; // this cycle's events
  logic access; // apb access phase
  logic wrAccept; // write takes effect
  logic [31:0] readMux; // read data before the flop
  logic mapped; // address hits a register

  // true for any of our three device codes
  function automatic logic isOurCode(input logic [5:0] code);
    isOurCode = (code == ipc_pkg::DEV_CODE_A) || (code == ipc_pkg::DEV_CODE_B) ||
      (code == ipc_pkg::DEV_CODE_C);
  endfunction

  // address compare shared by write and read paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  // ********
  // instruction decode and control pulses
  // ********
  // select levels come straight from the word so pulses and levels align
  always_comb begin
    isIot = instrWord[ipc_pkg::OPC_MSB:ipc_pkg::OPC_LSB] == ipc_pkg::OPC_IOT;
    devCode = instrWord[ipc_pkg::DEV_MSB:ipc_pkg::DEV_LSB];
    selPlotter = isIot && isOurCode(devCode) && cmdEnable;
    selFirst = selPlotter && !instrWord[ipc_pkg::DEV_BIT_SEVEN] && !instrWord[ipc_pkg::DEV_BIT_EIGHT];
    selBit7 = selPlotter && instrWord[ipc_pkg::DEV_BIT_SEVEN];
    selBit8 = selPlotter && instrWord[ipc_pkg::DEV_BIT_EIGHT];
    // pulses are strobes from the host, used as-is
    cmd.skipIfDone = selFirst && ioTimingPulse[ipc_pkg::IOP_ONE];
    cmd.clearDone = selFirst && ioTimingPulse[ipc_pkg::IOP_TWO];
    cmd.raisePen = selFirst && ioTimingPulse[ipc_pkg::IOP_FOUR];
    cmd.lowerPen = selBit7 && ioTimingPulse[ipc_pkg::IOP_FOUR];
    cmd.penStepLeft = selBit7 && ioTimingPulse[ipc_pkg::IOP_ONE];
    cmd.penStepRight = selBit8 && ioTimingPulse[ipc_pkg::IOP_ONE];
    // drum up answers on 51 and 52, so it pairs with either pen step
    cmd.drumStepUp = selPlotter && !selFirst && ioTimingPulse[ipc_pkg::IOP_TWO];
    cmd.drumStepDown = selBit8 && ioTimingPulse[ipc_pkg::IOP_FOUR];
  end

  // registered copies of the select levels for the outside
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      plotterSelectLevel <= 1'b0;
      firstCodeSelect <= 1'b0;
      firstCodeSelectN <= 1'b0;
    end else begin
      plotterSelectLevel <= selPlotter;
      firstCodeSelect <= selFirst;
      firstCodeSelectN <= selPlotter && !selFirst;
    end
  end

  // ********
  // motion control flip-flops
  // ********
  assign presetNow = ioPresetPulse || softPreset;
  assign anyFast = motion.penLeft || motion.penRight || motion.drumUp || motion.drumDown;

  // fast flops: set wins over the clear so a step is never lost
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      motion.penLeft <= 1'b0;
      motion.penRight <= 1'b0;
      motion.drumUp <= 1'b0;
      motion.drumDown <= 1'b0;
    end else begin
      motion.penLeft <= cmd.penStepLeft || (motion.penLeft && !fastMotionDone);
      motion.penRight <= cmd.penStepRight || (motion.penRight && !fastMotionDone);
      motion.drumUp <= cmd.drumStepUp || (motion.drumUp && !fastMotionDone);
      motion.drumDown <= cmd.drumStepDown || (motion.drumDown && !fastMotionDone);
    end
  end

  // pen flops: the two pen states exclude each other
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      motion.penUp <= 1'b0;
      motion.penDown <= 1'b0;
    end else begin
      if (cmd.raisePen) begin
        motion.penUp <= 1'b1;
        motion.penDown <= 1'b0;
      end else if (cmd.lowerPen) begin
        motion.penDown <= 1'b1;
        motion.penUp <= 1'b0;
      end else if (slowMotionDone) begin
        motion.penUp <= 1'b0;
      end
    end
  end

  // slow flop: held through both slow delays
  always_ff @(posedge clk_sys) begin
    if (rst || presetNow) begin
      slowFlop <= 1'b0;
    end else if (cmd.raisePen || cmd.lowerPen) begin
      slowFlop <= 1'b1;
    end else if (phase == ipc_pkg::PH_SLOW2 && timerExpire) begin
      slowFlop <= 1'b0;
    end
  end

  // ********
  // delay chain
  // ********
  // a fast command in the first fast delay, or a pen command in a slow chain, rides on that chain
  always_comb begin
    next_phase = phase;
    timerStart = 1'b0;
    timerLoad = '0;
    fastMotionDone = presetNow;
    slowMotionDone = 1'b0;
    setDone = 1'b0;
    unique case (phase)
      ipc_pkg::PH_IDLE: begin
        if (anyFast) begin
          timerStart = 1'b1;
          timerLoad = ipc_pkg::TIMER_W'(FAST_FIRST_CYCLES);
          next_phase = ipc_pkg::PH_FAST1;
        end else if (slowFlop) begin
          timerStart = 1'b1;
          timerLoad = ipc_pkg::TIMER_W'(SLOW_DELAY_CYCLES);
          next_phase = ipc_pkg::PH_SLOW1;
        end
      end
      ipc_pkg::PH_FAST1: begin
        if (timerExpire) begin
          fastMotionDone = 1'b1;
          timerStart = 1'b1;
          timerLoad = ipc_pkg::TIMER_W'(FAST_SECOND_CYCLES);
          next_phase = ipc_pkg::PH_FAST2;
        end
      end
      ipc_pkg::PH_FAST2: begin
        if (timerExpire) begin
          setDone = 1'b1;
          next_phase = ipc_pkg::PH_IDLE;
        end
      end
      ipc_pkg::PH_SLOW1: begin
        if (timerExpire) begin
          slowMotionDone = 1'b1;
          timerStart = 1'b1;
          timerLoad = ipc_pkg::TIMER_W'(SLOW_DELAY_CYCLES);
          next_phase = ipc_pkg::PH_SLOW2;
        end
      end
      ipc_pkg::PH_SLOW2: begin
        if (timerExpire) begin
          setDone = 1'b1;
          next_phase = ipc_pkg::PH_IDLE;
        end
      end
      default: begin
        next_phase = ipc_pkg::PH_IDLE; // illegal code recovers
      end
    endcase
    if (presetNow) begin
      timerStart = 1'b0;
      setDone = 1'b0;
      next_phase = ipc_pkg::PH_IDLE;
    end
  end

  // phase register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase <= ipc_pkg::PH_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  // shared timer: the chain never needs two delays at once
  ipc_delay_timer u_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(timerStart),
    .abort(presetNow),
    .loadCount(timerLoad),
    .expire(timerExpire),
    .busy()
  );

  // ********
  // done flag, interrupt line and skip
  // ********
  // set beats the clear instruction landing in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst || presetNow) begin
      motionDoneFlag <= 1'b0;
    end else if (setDone) begin
      motionDoneFlag <= 1'b1;
    end else if (cmd.clearDone) begin
      motionDoneFlag <= 1'b0;
    end
  end

  // line is low while the flag is set; skip only on the test pulse
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      interruptRequestLineN <= 1'b1;
      skipRequest <= 1'b0;
    end else begin
      interruptRequestLineN <= !((motionDoneFlag && !cmd.clearDone) || setDone) || presetNow;
      skipRequest <= cmd.skipIfDone && motionDoneFlag;
    end
  end

  // ********
  // apb slave
  // ********
  assign access = psel && penable;
  assign wrAccept = access && pready && pwrite;
  assign mapped = hit(paddr, ipc_pkg::ADDR_CTRL) || hit(paddr, ipc_pkg::ADDR_STATUS) ||
    hit(paddr, ipc_pkg::ADDR_IRQ_STAT) || hit(paddr, ipc_pkg::ADDR_IRQ_MASK);

  // read mux; unmapped and reserved bits read zero
  always_comb begin
    readMux = 32'h0000_0000;
    if (hit(paddr, ipc_pkg::ADDR_CTRL)) begin
      readMux[ipc_pkg::CTRL_CMD_ENABLE] = cmdEnable;
    end else if (hit(paddr, ipc_pkg::ADDR_STATUS)) begin
      readMux[ipc_pkg::ST_DONE] = motionDoneFlag;
      readMux[ipc_pkg::ST_MOTION_LSB +: 6] = motion;
      readMux[ipc_pkg::ST_PHASE_LSB +: 5] = phase;
      readMux[ipc_pkg::ST_SLOW] = slowFlop;
    end else if (hit(paddr, ipc_pkg::ADDR_IRQ_STAT)) begin
      readMux[ipc_pkg::EV_W-1:0] = irqStat;
    end else if (hit(paddr, ipc_pkg::ADDR_IRQ_MASK)) begin
      readMux[ipc_pkg::EV_W-1:0] = irqMask;
    end
  end

  // one wait state: data, error and pready are flopped on the same edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (access && !pready) begin
      pready <= 1'b1;
      pslverr <= !mapped;
      prdata <= pwrite ? 32'h0000_0000 : readMux;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // control register and the self-clearing soft preset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cmdEnable <= ipc_pkg::CTRL_CMD_ENABLE_RST;
      softPreset <= 1'b0;
    end else begin
      softPreset <= wrAccept && hit(paddr, ipc_pkg::ADDR_CTRL) && pwdata[ipc_pkg::CTRL_SOFT_PRESET];
      if (wrAccept && hit(paddr, ipc_pkg::ADDR_CTRL)) begin
        cmdEnable <= pwdata[ipc_pkg::CTRL_CMD_ENABLE];
      end
    end
  end

  // ********
  // interrupt status and mask
  // ********
  always_comb begin
    events = '0;
    events[ipc_pkg::EV_DONE] = setDone;
    events[ipc_pkg::EV_FAST] = (phase == ipc_pkg::PH_FAST1) && timerExpire && !presetNow;
    events[ipc_pkg::EV_SLOW] = slowMotionDone && !presetNow;
  end

  // write one clears; a same-cycle event keeps its bit set
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irqStat <= '0;
    end else if (wrAccept && hit(paddr, ipc_pkg::ADDR_IRQ_STAT)) begin
      irqStat <= (irqStat & ~pwdata[ipc_pkg::EV_W-1:0]) | events;
    end else begin
      irqStat <= irqStat | events;
    end
  end

  // mask register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irqMask <= ipc_pkg::IRQ_MASK_RST;
    end else if (wrAccept && hit(paddr, ipc_pkg::ADDR_IRQ_MASK)) begin
      irqMask <= pwdata[ipc_pkg::EV_W-1:0];
    end
  end

  // level interrupt, one cycle behind the status bits
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat & irqMask);
    end
  end

endmodule
`default_nettype wire

/* File: ipc_plotter_control_sva.sv */
// port-level assertions for the plotter control block
`timescale 1ns/10ps
`default_nettype none
module ipc_plotter_control_sva #(
  parameter int FAST_FIRST_CYCLES = 20,
  parameter int FAST_SECOND_CYCLES = 20,
  parameter int SLOW_DELAY_CYCLES = 40
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [11:0] instrWord,
  input wire logic [2:0] ioTimingPulse,
  input wire logic ioPresetPulse,
  input wire logic plotterSelectLevel,
  input wire logic firstCodeSelect,
  input wire logic firstCodeSelectN,
  input wire logic skipRequest,
  input wire logic interruptRequestLineN,
  input wire logic motionDoneFlag,
  input wire ipc_pkg::ipc_motion_t motion
);
  // ********
  // helpers
  // ********
  // windows carry a little slack: pipeline stages are the designer's choice
  localparam int FLO = FAST_FIRST_CYCLES - 1;
  localparam int FHI = FAST_FIRST_CYCLES + 3;
  localparam int DLO = FAST_SECOND_CYCLES - 2;
  localparam int DHI = FAST_SECOND_CYCLES + 3;
  localparam int SLO = SLOW_DELAY_CYCLES - 2;
  localparam int SHI = SLOW_DELAY_CYCLES + 3;
  logic ours; // word is an i/o instruction for this block
  logic fastAny; // some fast flop is set
  logic skipCause; // flag test while the flag is up
  assign ours = instrWord[11:9] == ipc_pkg::OPC_IOT
    && instrWord[8:3] inside {ipc_pkg::DEV_CODE_A, ipc_pkg::DEV_CODE_B, ipc_pkg::DEV_CODE_C};
  assign fastAny = |motion[3:0];
  assign skipCause = ours && instrWord[8:3] == ipc_pkg::DEV_CODE_A && ioTimingPulse[ipc_pkg::IOP_ONE] && motionDoneFlag;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ********
  // properties
  // ********
  select_gate_a: assert property (!ours |=> !plotterSelectLevel) else $error("select without our code");
  first_code_a: assert property (firstCodeSelect |-> plotterSelectLevel && $past(instrWord[4:3]) == 2'b00)
    else $error("first-code select wrong");
  first_inverse_a: assert property (firstCodeSelectN == (plotterSelectLevel && !firstCodeSelect))
    else $error("inverse select wrong");
  skip_cause_a: assert property (skipRequest |-> $past(skipCause)) else $error("skip without cause");
  irq_line_a: assert property (interruptRequestLineN != motionDoneFlag) else $error("interrupt line wrong");
  preset_clear_a: assert property (ioPresetPulse && ioTimingPulse == 3'h0 |=> !motionDoneFlag && !fastAny)
    else $error("preset left state");
  motion_set_a: assert property (ioTimingPulse[ipc_pkg::IOP_ONE] && plotterSelectLevel && $stable(instrWord)
    && instrWord[8:3] == ipc_pkg::DEV_CODE_B && !ioPresetPulse && !fastAny |=> motion.penRight)
    else $error("pen right not set");
  fast_hold_a: assert property ($rose(fastAny) |-> ##[FLO:FHI] !fastAny) else $error("fast step length");
  fast_done_a: assert property ($fell(fastAny) && !$past(ioPresetPulse) |-> ##[DLO:DHI] motionDoneFlag)
    else $error("fast done late");
  slow_hold_a: assert property ($rose(motion.penUp) |-> ##[SLO:SHI] !motion.penUp) else $error("pen up length");
  slow_done_a: assert property ($fell(motion.penUp) |-> ##[SLO:SHI] motionDoneFlag)
    else $error("slow done late");
endmodule
bind ipc_plotter_control ipc_plotter_control_sva #(.FAST_FIRST_CYCLES(FAST_FIRST_CYCLES),
  .FAST_SECOND_CYCLES(FAST_SECOND_CYCLES), .SLOW_DELAY_CYCLES(SLOW_DELAY_CYCLES)) u_sva (
  .clk_sys(clk_sys), .rst(rst), .instrWord(instrWord), .ioTimingPulse(ioTimingPulse), .ioPresetPulse(ioPresetPulse),
  .plotterSelectLevel(plotterSelectLevel), .firstCodeSelect(firstCodeSelect), .firstCodeSelectN(firstCodeSelectN),
  .skipRequest(skipRequest), .interruptRequestLineN(interruptRequestLineN), .motionDoneFlag(motionDoneFlag),
  .motion(motion));
`default_nettype wire

/* File: ipc_plotter_mech.sv */
// behavioural drum plotter: one step per rising motion level
`timescale 1ns/10ps
`default_nettype none
module ipc_plotter_mech (
  input wire logic clk_sys,
  input wire logic rst,
  input wire ipc_pkg::ipc_motion_t motion,
  output logic signed [15:0] posX,
  output logic signed [15:0] posY,
  output logic penOnPaper
);
  ipc_pkg::ipc_motion_t prev; // levels seen last cycle
  ipc_pkg::ipc_motion_t rise; // fresh motion requests
  assign rise = motion & ~prev;
  // the carriage moves once per command, however long the level stands
  always @(posedge clk_sys) begin
    prev <= rst ? '0 : motion;
    if (rst) begin
      posX <= '0;
      posY <= '0;
      penOnPaper <= 1'b0;
    end else begin
      posX <= posX + 16'(rise.penRight) - 16'(rise.penLeft);
      posY <= posY + 16'(rise.drumUp) - 16'(rise.drumDown);
      if (rise.penDown) penOnPaper <= 1'b1;
      if (rise.penUp) penOnPaper <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: incremental_plotter_control_bench.sv */
// self-checking bench for the plotter control block
`timescale 1ns/10ps
`default_nettype none
module incremental_plotter_control_bench;
  localparam int FF = 20; // shortened delays keep the run short
  localparam int FS = 20;
  localparam int SL = 40;
  // fast table: code 52 flag, pulses, expected left/right/up/down, steps
  localparam logic [4:0] TC = 5'b10100;
  localparam logic [2:0] TP [5] = '{3'h1, 3'h3, 3'h3, 3'h5, 3'h2};
  localparam logic [3:0] TF [5] = '{4'h4, 4'h6, 4'hA, 4'h5, 4'h2};
  localparam int TX [5] = '{1, 1, -1, 1, 0};
  localparam int TY [5] = '{0, 1, 1, -1, 1};
  logic clk_sys = 1'b0;
  logic rst, ioPresetPulse, plotterSelectLevel, firstCodeSelect, firstCodeSelectN, skipRequest;
  logic interruptRequestLineN, motionDoneFlag, psel, penable, pwrite, pready, pslverr, irq, penOnPaper, skipSeen;
  logic [11:0] instrWord;
  logic [2:0] ioTimingPulse;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic signed [15:0] posX, posY;
  ipc_pkg::ipc_motion_t motion;
  int n_errors = 0, checks = 0, n, ex = 0, ey = 0;
  always #4 clk_sys = ~clk_sys;
  ipc_plotter_control #(.FAST_FIRST_CYCLES(FF), .FAST_SECOND_CYCLES(FS), .SLOW_DELAY_CYCLES(SL)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .instrWord(instrWord), .ioTimingPulse(ioTimingPulse), .ioPresetPulse(ioPresetPulse),
    .plotterSelectLevel(plotterSelectLevel), .firstCodeSelect(firstCodeSelect), .firstCodeSelectN(firstCodeSelectN),
    .skipRequest(skipRequest), .interruptRequestLineN(interruptRequestLineN), .motionDoneFlag(motionDoneFlag),
    .motion(motion), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  ipc_plotter_mech u_mech (.clk_sys(clk_sys), .rst(rst), .motion(motion), .posX(posX), .posY(posY),
    .penOnPaper(penOnPaper));
  // ********
  // helpers
  // ********
  function automatic logic [11:0] op(input logic [5:0] dev, input logic [2:0] p);
    return {ipc_pkg::OPC_IOT, dev, p};
  endfunction
  task automatic report_and_stop();
    if (n_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // host i/o cycle: word first, then each selected pulse for one cycle
  task automatic iot(input logic [11:0] w);
    instrWord <= w;
    @(posedge clk_sys);
    for (int i = 0; i < 3; i++) begin
      if (w[i]) begin
        ioTimingPulse <= 3'(1 << i);
        @(posedge clk_sys);
        ioTimingPulse <= 3'h0;
        @(posedge clk_sys);
        if (i == 0) skipSeen = skipRequest;
      end
    end
  endtask
  // apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q, x);
    chk(32'(e), 32'(xe));
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    repeat (2) @(posedge clk_sys);
  endtask
  // wait for the flag with no limit of its own, then check the elapsed count
  task automatic done_in(input int lo, input int hi);
    n = 0;
    while (motionDoneFlag !== 1'b1) begin
      @(posedge clk_sys);
      n++;
    end
    chk(32'(n >= lo && n <= hi), 32'h0000_0001);
  endtask
  // ********
  // tests
  // ********
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    instrWord = '0;
    ioTimingPulse = '0;
    ioPresetPulse = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    chk(32'({interruptRequestLineN, motionDoneFlag, motion, irq}), 32'h0000_0100);
    rd(ipc_pkg::ADDR_CTRL, 32'h0000_0002, 1'b0);
    rd(ipc_pkg::ADDR_STATUS, 32'h0000_0080, 1'b0);
    rd(ipc_pkg::ADDR_IRQ_MASK, 32'h0000_0000, 1'b0);
    rd(8'h10, 32'h0000_0000, 1'b1);
    // codes 50..54: only the first three select, 50 alone is first code
    for (int i = 0; i < 5; i++) begin
      instrWord <= op(6'h28 + 6'(i), 3'h0);
      repeat (2) @(posedge clk_sys);
      chk(32'({plotterSelectLevel, firstCodeSelect, firstCodeSelectN}), 32'({i < 3, i == 0, i == 1 || i == 2}));
    end
    iot({3'h7, ipc_pkg::DEV_CODE_B, 3'h1});
    iot(op(6'h2B, 3'h1));
    chk(32'(motion), 32'h0000_0000);
    iot(op(ipc_pkg::DEV_CODE_A, 3'h1));
    chk(32'(skipSeen), 32'h0000_0000);
    wr(ipc_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
    for (int i = 0; i < 5; i++) begin
      iot(op(TC[i] ? ipc_pkg::DEV_CODE_C : ipc_pkg::DEV_CODE_B, TP[i]));
      chk(32'(motion[3:0]), 32'(TF[i]));
      ex += TX[i];
      ey += TY[i];
      done_in(FF + FS - 3, FF + FS + 4);
      repeat (2) @(posedge clk_sys);
      chk(32'({motion, interruptRequestLineN, irq}), 32'h0000_0001);
      chk({posX, posY}, {16'(ex), 16'(ey)});
      iot(op(ipc_pkg::DEV_CODE_A, 3'h3));
      chk(32'({skipSeen, motionDoneFlag, interruptRequestLineN}), 32'h0000_0005);
    end
    rd(ipc_pkg::ADDR_IRQ_STAT, 32'h0000_0003, 1'b0);
    chk(32'(irq), 32'h0000_0001);
    wr(ipc_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    wr(ipc_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
    chk(32'(irq), 32'h0000_0001);
    wr(ipc_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
    chk(32'(irq), 32'h0000_0000);
    // slow moves: pen down, then clear flag and lift pen in one word
    iot(op(ipc_pkg::DEV_CODE_C, 3'h4));
    done_in(2 * SL - 3, 2 * SL + 4);
    chk(32'({motion, penOnPaper}), 32'h0000_0021);
    iot(op(ipc_pkg::DEV_CODE_A, 3'h6));
    n = 0;
    while (motion.penUp === 1'b1) begin
      @(posedge clk_sys);
      n++;
    end
    chk(32'(n >= SL - 3 && n <= SL + 3), 32'h0000_0001);
    chk(32'({motion, penOnPaper}), 32'h0000_0000);
    done_in(SL - 3, SL + 4);
    rd(ipc_pkg::ADDR_IRQ_STAT, 32'h0000_0007, 1'b0);
    // commands refused while disabled
    wr(ipc_pkg::ADDR_CTRL, 32'h0000_0001);
    iot(op(ipc_pkg::DEV_CODE_B, 3'h1));
    chk(32'({motionDoneFlag, plotterSelectLevel, motion}), 32'h0000_0000);
    wr(ipc_pkg::ADDR_CTRL, 32'h0000_0002);
    // preset in mid-step with the flag already cleared by the soft preset
    iot(op(ipc_pkg::DEV_CODE_B, 3'h1));
    ioPresetPulse <= 1'b1;
    @(posedge clk_sys);
    ioPresetPulse <= 1'b0;
    repeat (FF + FS + 10) @(posedge clk_sys);
    chk(32'({motionDoneFlag, motion}), 32'h0000_0000);
    rd(ipc_pkg::ADDR_STATUS, 32'h0000_0080, 1'b0);
    chk({posX, posY}, {16'(ex + 1), 16'(ey)});
    report_and_stop();
  end
endmodule
`default_nettype wire
